// ---- iilc_pkg.sv ----
package iilc_pkg;

  localparam int unsigned NUM_REGS = 16;
  localparam int unsigned CNT_W    = 7;

  localparam logic [3:0] COUNT_REG = 4'h1;

  localparam logic [6:0] LAT_ALU        = 7'h01;
  localparam logic [6:0] LAT_SHIFT_IMM  = 7'h01;
  localparam logic [6:0] LAT_SHIFT_REG  = 7'h03;
  localparam logic [6:0] LAT_IMUL32     = 7'h05;
  localparam logic [6:0] LAT_IMUL16     = 7'h06;
  localparam logic [6:0] LAT_LEA        = 7'h01;
  localparam logic [6:0] LAT_LOAD       = 7'h03;
  localparam logic [6:0] LAT_STACK_FP_ADD       = 7'h05;
  localparam logic [6:0] LAT_STACK_FP_ADD_PD    = 7'h06;
  localparam logic [6:0] LAT_STACK_FP_MULTIPLY_SS    = 7'h04;
  localparam logic [6:0] LAT_STACK_FP_MULTIPLY       = 7'h05;
  localparam logic [6:0] LAT_STACK_FP_MULTIPLY_PD    = 7'h09;
  localparam logic [6:0] LAT_FP2INT     = 7'h01;
  localparam logic [6:0] NARROW_EXTRA   = 7'h01;
  localparam logic [6:0] LINE_SPLIT     = 7'h0e;
  localparam logic [6:0] FP_WB_EXTRA    = 7'h02;
  localparam logic [6:0] DIV_SETUP      = 7'h02;
  localparam logic [6:0] DIV_MAX_BITS   = 7'h40;

  localparam logic [3:0] IMUL_BLOCK     = 4'h4;
  localparam logic [3:0] THR_STACK_FP_ADD_PD    = 4'h5;
  localparam logic [3:0] THR_STACK_FP_MULTIPLY_SLOW  = 4'h2;
  localparam logic [3:0] THR_STACK_FP_MULTIPLY_PD    = 4'h9;

  typedef enum logic [4:0] {
    OP_ALU, OP_SHIFT_IMM, OP_SHIFT_REG, OP_IMUL32, OP_IMUL16, OP_LEA, OP_LOAD,
    OP_POP, OP_STORE, OP_STACK_FP_ADD, OP_ADD_SCALAR, OP_ADD_PS, OP_ADD_PD,
    OP_MUL_SS, OP_MUL_SD, OP_MUL_PS, OP_STACK_FP_MULTIPLY, OP_MUL_PD, OP_DIV,
    OP_FP_TO_INT_CONVERSION, OP_UNALIGNED_VECTOR_LOAD
  } iilc_op_t;

  typedef enum logic [2:0] {
    UNIT_ALU, UNIT_IMUL, UNIT_STACK_FP_ADD, UNIT_STACK_FP_MULTIPLY, UNIT_DIV, UNIT_MEM
  } iilc_unit_t;

  typedef struct packed {
    iilc_op_t    op;
    logic        thread;
    logic [3:0]  dst;
    logic        dst_we;
    logic [1:0]  sub_byte;
    logic [3:0]  src_a;
    logic        src_a_en;
    logic [3:0]  src_b;
    logic        src_b_en;
    logic        narrow;
    logic        line_cross;
    logic [6:0]  div_bits;
  } iilc_insn_t;

  typedef struct packed {
    logic        valid;
    iilc_insn_t  insn;
    logic [6:0]  lat;
  } iilc_issue_t;

  typedef struct packed {
    logic        valid;
    logic        simd;
    logic [1:0]  simd_type;
    logic        event_b;
  } iilc_retire_t;

endpackage

// ---- iilc_ready_slot.sv ----
`timescale 1ns/10ps
`default_nettype none

module iilc_ready_slot #(
  parameter int unsigned W = 7
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic [W-1:0]  load_cnt,
  input  wire logic          load_fp,
  output logic      [W-1:0]  cnt,
  output logic               fp
);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_cnt;
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fp <= 1'b0;
    end else if (load) begin
      fp <= load_fp;
    end
  end

endmodule

`default_nettype wire

// ---- iilc_divider.sv ----
`timescale 1ns/10ps
`default_nettype none

module iilc_divider
  import iilc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  req,
  output logic      [1:0]  grant,
  input  wire logic        start,
  input  wire logic        start_thread,
  input  wire logic [6:0]  start_bits,
  output logic             busy,
  output logic             owner
);

  logic [6:0] iter_reg;
  logic       last_reg;

  // When both slots request, the thread of the last start picks the slot: slot 0 after thread 1, else slot 1
  always_comb begin
    grant = 2'b00;
    if (!busy) begin
      if (req == 2'b11) begin
        grant = last_reg ? 2'b01 : 2'b10;
      end else begin
        grant = req;
      end
    end
  end

  // One quotient bit per cycle, so the occupancy tracks the operand size
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      iter_reg <= '0;
    end else if (start) begin
      iter_reg <= DIV_SETUP + ((start_bits > DIV_MAX_BITS) ? DIV_MAX_BITS : start_bits);
    end else if (iter_reg != '0) begin
      iter_reg <= iter_reg - 7'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_reg <= 1'b0;
    end else if (start) begin
      last_reg <= start_thread;
    end
  end

  assign busy  = (iter_reg != '0);
  assign owner = last_reg;

endmodule

`default_nettype wire

// ---- iilc_issue_ctrl.sv ----
// Summary of operation
// - Up to two issues per cycle, in order
// - Multiplier pipelined alongside other long operations
// - Multiply holds younger single-cycle ops four cycles
// - Independent multiply may follow one cycle later
// - Immediate-count shift has one-cycle latency
// - Register-count shift waits count register, three cycles
// - Subregisters tracked as one full register
// - Narrow-input address, load, pop take longer
// - FP add five cycles; packed double six, throughput five
// - FP multiply four or five cycles, throughput
// - Packed-double multiply nine cycles, blocks multiplier nine
// - Radix-2 divider, latency set by operand size only
// - One divider shared by two threads, arbitrated
// - Non-FP consumers of FP results wait two extra cycles
// - Line-crossing unaligned vector load adds fourteen cycles
// - Memory hazard blocks later short-latency issue
// - Event counts reissued memory instructions
// - Events count divides and divider busy cycles
// - Retired SIMD events by type, plus assist event
`timescale 1ns/10ps
`default_nettype none

module iilc_issue_ctrl
  import iilc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                fe_valid,
  input  wire iilc_pkg::iilc_insn_t fe_insn0,
  input  wire iilc_pkg::iilc_insn_t fe_insn1,
  output logic                     fe_ready,
  input  wire logic                mem_hazard_busy,
  input  wire logic                mem_memory_event_a,
  input  wire iilc_pkg::iilc_retire_t retire,
  output iilc_pkg::iilc_issue_t    iss0,
  output iilc_pkg::iilc_issue_t    iss1,
  output logic                     ev_memory_event_a,
  output logic                     ev_div_start,
  output logic                     ev_div_busy_cycle,
  output logic [3:0]               ev_simd_retired_by_type_event,
  output logic                     ev_event_b
);

  import iilc_pkg::*;

  function automatic iilc_unit_t unit_of(input iilc_op_t op);
    unique case (op)
      OP_IMUL32, OP_IMUL16:                                 unit_of = UNIT_IMUL;
      OP_STACK_FP_ADD, OP_ADD_SCALAR, OP_ADD_PS, OP_ADD_PD: unit_of = UNIT_STACK_FP_ADD;
      OP_MUL_SS, OP_MUL_SD, OP_MUL_PS, OP_STACK_FP_MULTIPLY,
      OP_MUL_PD:                                            unit_of = UNIT_STACK_FP_MULTIPLY;
      OP_DIV:                                               unit_of = UNIT_DIV;
      OP_LOAD, OP_POP, OP_STORE, OP_UNALIGNED_VECTOR_LOAD:  unit_of = UNIT_MEM;
      default:                                              unit_of = UNIT_ALU;
    endcase
  endfunction

  function automatic logic is_fp(input iilc_op_t op);
    is_fp = (unit_of(op) == UNIT_STACK_FP_ADD) || (unit_of(op) == UNIT_STACK_FP_MULTIPLY) ||
            (op == OP_DIV) || (op == OP_UNALIGNED_VECTOR_LOAD);
  endfunction

  function automatic logic is_short_int(input iilc_op_t op);
    is_short_int = (op == OP_ALU) || (op == OP_SHIFT_IMM) || (op == OP_LEA) ||
                   (op == OP_LOAD) || (op == OP_POP) || (op == OP_STORE);
  endfunction

  function automatic logic [6:0] lat_of(input iilc_insn_t i);
    logic [6:0] l;
    l = LAT_ALU;
    unique case (i.op)
      OP_SHIFT_IMM:            l = LAT_SHIFT_IMM;
      OP_SHIFT_REG:            l = LAT_SHIFT_REG;
      OP_IMUL32:               l = LAT_IMUL32;
      OP_IMUL16:               l = LAT_IMUL16;
      OP_LEA:                  l = LAT_LEA;
      OP_LOAD, OP_POP:         l = LAT_LOAD;
      OP_UNALIGNED_VECTOR_LOAD: l = LAT_LOAD;
      OP_STACK_FP_ADD, OP_ADD_SCALAR, OP_ADD_PS: l = LAT_STACK_FP_ADD;
      OP_ADD_PD:               l = LAT_STACK_FP_ADD_PD;
      OP_MUL_SS:               l = LAT_STACK_FP_MULTIPLY_SS;
      OP_MUL_SD, OP_MUL_PS, OP_STACK_FP_MULTIPLY: l = LAT_STACK_FP_MULTIPLY;
      OP_MUL_PD:               l = LAT_STACK_FP_MULTIPLY_PD;
      OP_DIV: begin
        l = DIV_SETUP + ((i.div_bits > DIV_MAX_BITS) ? DIV_MAX_BITS : i.div_bits);
      end
      OP_FP_TO_INT_CONVERSION: l = LAT_FP2INT;
      default:                 l = LAT_ALU;
    endcase
    if (i.narrow && ((i.op == OP_LEA) || (i.op == OP_LOAD) || (i.op == OP_POP))) begin
      l = l + NARROW_EXTRA;
    end
    if ((i.op == OP_UNALIGNED_VECTOR_LOAD) && i.line_cross) begin
      l = l + LINE_SPLIT;
    end
    if (is_fp(i.op)) begin
      l = l + FP_WB_EXTRA;
    end
    lat_of = l;
  endfunction

  iilc_insn_t        q_reg [2];
  logic [1:0]        qv_reg;
  logic [CNT_W-1:0]  sb_cnt [NUM_REGS];
  logic              sb_fp  [NUM_REGS];
  logic [NUM_REGS-1:0] sb_load;
  logic [CNT_W-1:0]  sb_load_cnt [NUM_REGS];
  logic [NUM_REGS-1:0] sb_load_fp;
  logic [3:0]        imul_blk_reg;
  logic [3:0]        stack_fp_add_busy_reg;
  logic [3:0]        stack_fp_multiply_busy_reg;
  logic [1:0]        cand_ok;
  logic [1:0]        div_req;
  logic [1:0]        div_grant;
  logic              div_busy;
  logic              div_start;
  logic              div_start_thread;
  logic [6:0]        div_start_bits;
  logic              pair_dep;
  logic              pair_unit_clash;
  logic              go0;
  logic              go1;
  logic [1:0]        qv_next;

  // Scoreboard holds one countdown per full architectural register
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_sb
      iilc_ready_slot #(.W(CNT_W)) u_slot (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (sb_load[g]),
        .load_cnt (sb_load_cnt[g]),
        .load_fp  (sb_load_fp[g]),
        .cnt      (sb_cnt[g]),
        .fp       (sb_fp[g])
      );
    end
  endgenerate

  // An FP consumer reads the FP result early; others see the later writeback
  function automatic logic src_ready(input logic [3:0] r, input logic en, input logic fpc);
    src_ready = !en || (sb_cnt[r] == '0) ||
                (fpc && sb_fp[r] && (sb_cnt[r] <= FP_WB_EXTRA));
  endfunction

  function automatic logic unit_free(input iilc_op_t op);
    unique case (unit_of(op))
      UNIT_STACK_FP_ADD: unit_free = (stack_fp_add_busy_reg == '0);
      UNIT_STACK_FP_MULTIPLY: unit_free = (stack_fp_multiply_busy_reg == '0);
      UNIT_DIV:  unit_free = !div_busy;
      default:   unit_free = 1'b1;
    endcase
  endfunction

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      cand_ok[k] = qv_reg[k] &&
        src_ready(q_reg[k].src_a, q_reg[k].src_a_en, is_fp(q_reg[k].op)) &&
        src_ready(q_reg[k].src_b, q_reg[k].src_b_en, is_fp(q_reg[k].op)) &&
        src_ready(q_reg[k].dst, q_reg[k].dst_we, 1'b0) &&
        src_ready(COUNT_REG, q_reg[k].op == OP_SHIFT_REG, 1'b0) &&
        !(is_short_int(q_reg[k].op) && (imul_blk_reg != '0)) &&
        !(is_short_int(q_reg[k].op) && mem_hazard_busy) &&
        unit_free(q_reg[k].op);
      div_req[k] = cand_ok[k] && (q_reg[k].op == OP_DIV);
    end
  end

  // At most one slot starts a divide, since a pair never shares a non-ALU unit
  always_comb begin
    div_start = (go0 && div_req[0]) || (go1 && div_req[1]);
    if (go0 && div_req[0]) begin
      div_start_thread = q_reg[0].thread;
      div_start_bits   = q_reg[0].div_bits;
    end else begin
      div_start_thread = q_reg[1].thread;
      div_start_bits   = q_reg[1].div_bits;
    end
  end

  iilc_divider u_div (
    .core_clk     (core_clk),
    .rst          (rst),
    .req          (div_req),
    .grant        (div_grant),
    .start        (div_start),
    .start_thread (div_start_thread),
    .start_bits   (div_start_bits),
    .busy         (div_busy),
    .owner        ()
  );

  // A younger op that reads or rewrites the older one's result cannot pair with it
  always_comb begin
    pair_dep = 1'b0;
    if (q_reg[0].dst_we) begin
      pair_dep = (q_reg[1].src_a_en && (q_reg[1].src_a == q_reg[0].dst)) ||
                 (q_reg[1].src_b_en && (q_reg[1].src_b == q_reg[0].dst)) ||
                 (q_reg[1].dst_we && (q_reg[1].dst == q_reg[0].dst)) ||
                 ((q_reg[1].op == OP_SHIFT_REG) && (q_reg[0].dst == COUNT_REG));
    end
    pair_unit_clash = (unit_of(q_reg[0].op) == unit_of(q_reg[1].op)) &&
                      (unit_of(q_reg[0].op) != UNIT_ALU);
  end

  // Slot 1 only goes with slot 0 and must not touch its register or non-ALU unit
  always_comb begin
    go0 = cand_ok[0] && (!div_req[0] || div_grant[0]);
    go1 = go0 && cand_ok[1] && (!div_req[1] || div_grant[1]) &&
          !pair_dep && !pair_unit_clash &&
          !((unit_of(q_reg[0].op) == UNIT_IMUL) && is_short_int(q_reg[1].op));
  end

  always_comb begin
    sb_load = '0;
    sb_load_fp = '0;
    for (int r = 0; r < NUM_REGS; r++) begin
      sb_load_cnt[r] = '0;
    end
    // Count reaches zero in the first cycle a consumer may issue
    if (go0 && q_reg[0].dst_we) begin
      sb_load[q_reg[0].dst] = 1'b1;
      sb_load_cnt[q_reg[0].dst] = lat_of(q_reg[0]) - 7'h01;
      sb_load_fp[q_reg[0].dst] = is_fp(q_reg[0].op);
    end
    if (go1 && q_reg[1].dst_we) begin
      sb_load[q_reg[1].dst] = 1'b1;
      sb_load_cnt[q_reg[1].dst] = lat_of(q_reg[1]) - 7'h01;
      sb_load_fp[q_reg[1].dst] = is_fp(q_reg[1].op);
    end
  end

  // The pair latch refills only once empty: costs a bubble, keeps fe_ready a flop
  always_comb begin
    unique case ({go1, go0})
      2'b11:   qv_next = 2'b00;
      2'b01:   qv_next = {1'b0, qv_reg[1]};
      default: qv_next = qv_reg;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qv_reg <= 2'b00;
      q_reg[0] <= '0;
      q_reg[1] <= '0;
    end else if (fe_valid && fe_ready) begin
      qv_reg <= 2'b11;
      q_reg[0] <= fe_insn0;
      q_reg[1] <= fe_insn1;
    end else begin
      qv_reg <= qv_next;
      if (go0 && !go1) begin
        q_reg[0] <= q_reg[1];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fe_ready <= 1'b0;
    end else begin
      fe_ready <= !(fe_valid && fe_ready) && (qv_next == 2'b00);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      imul_blk_reg <= '0;
    end else if ((go0 && unit_of(q_reg[0].op) == UNIT_IMUL) ||
                 (go1 && unit_of(q_reg[1].op) == UNIT_IMUL)) begin
      imul_blk_reg <= IMUL_BLOCK - 4'h1;
    end else if (imul_blk_reg != '0) begin
      imul_blk_reg <= imul_blk_reg - 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_fp_add_busy_reg <= '0;
    end else if ((go0 && q_reg[0].op == OP_ADD_PD) || (go1 && q_reg[1].op == OP_ADD_PD)) begin
      stack_fp_add_busy_reg <= THR_STACK_FP_ADD_PD - 4'h1;
    end else if (stack_fp_add_busy_reg != '0) begin
      stack_fp_add_busy_reg <= stack_fp_add_busy_reg - 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_fp_multiply_busy_reg <= '0;
    end else if ((go0 && q_reg[0].op == OP_MUL_PD) || (go1 && q_reg[1].op == OP_MUL_PD)) begin
      stack_fp_multiply_busy_reg <= THR_STACK_FP_MULTIPLY_PD - 4'h1;
    end else if ((go0 && unit_of(q_reg[0].op) == UNIT_STACK_FP_MULTIPLY && q_reg[0].op != OP_MUL_SS) ||
                 (go1 && unit_of(q_reg[1].op) == UNIT_STACK_FP_MULTIPLY && q_reg[1].op != OP_MUL_SS)) begin
      stack_fp_multiply_busy_reg <= THR_STACK_FP_MULTIPLY_SLOW - 4'h1;
    end else if (stack_fp_multiply_busy_reg != '0) begin
      stack_fp_multiply_busy_reg <= stack_fp_multiply_busy_reg - 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      iss0 <= '0;
      iss1 <= '0;
    end else begin
      iss0.valid <= go0;
      iss0.insn  <= q_reg[0];
      iss0.lat   <= lat_of(q_reg[0]);
      iss1.valid <= go1;
      iss1.insn  <= q_reg[1];
      iss1.lat   <= lat_of(q_reg[1]);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_memory_event_a <= 1'b0;
      ev_div_start      <= 1'b0;
      ev_div_busy_cycle <= 1'b0;
    end else begin
      ev_memory_event_a <= mem_memory_event_a;
      ev_div_start      <= div_start;
      ev_div_busy_cycle <= div_busy;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_simd_retired_by_type_event <= 4'h0;
      ev_event_b                    <= 1'b0;
    end else begin
      ev_simd_retired_by_type_event <= (retire.valid && retire.simd) ?
                                       (4'h1 << retire.simd_type) : 4'h0;
      ev_event_b <= retire.valid && retire.event_b;
    end
  end

endmodule

`default_nettype wire

// ---- iilc_issue_ctrl_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module iilc_issue_ctrl_assertions
  import iilc_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  fe_valid,
  input wire logic                  fe_ready,
  input wire logic                  mem_hazard_busy,
  input wire logic                  mem_memory_event_a,
  input wire iilc_pkg::iilc_retire_t retire,
  input wire iilc_pkg::iilc_issue_t  iss0,
  input wire iilc_pkg::iilc_issue_t  iss1,
  input wire logic                  ev_memory_event_a,
  input wire logic [3:0]            ev_simd_retired_by_type_event,
  input wire logic                  ev_event_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic short_any;
  logic mul0;
  logic mul_any;

  function automatic logic is_short(iilc_op_t op);
    return op inside {OP_ALU, OP_SHIFT_IMM, OP_LEA, OP_LOAD, OP_POP, OP_STORE};
  endfunction

  assign short_any = (iss0.valid && is_short(iss0.insn.op)) || (iss1.valid && is_short(iss1.insn.op));
  assign mul0 = iss0.valid && (iss0.insn.op inside {OP_IMUL32, OP_IMUL16});
  assign mul_any = mul0 || (iss1.valid && (iss1.insn.op inside {OP_IMUL32, OP_IMUL16}));

  sequence s_mul_issue;
    mul_any;
  endsequence
  sequence s_short_quiet;
    !short_any [*3];
  endsequence

  mul_holds_short_a: assert property (s_mul_issue |=> s_short_quiet)
    else $error("short op issued while multiply blocks");
  mul_pair_a: assert property (mul0 |-> !(iss1.valid && is_short(iss1.insn.op)))
    else $error("short op paired behind multiply");
  slot_order_a: assert property (iss1.valid |-> iss0.valid)
    else $error("younger slot issued alone");
  common_dst_a: assert property (iss0.valid && iss1.valid && iss0.insn.dst_we && iss1.insn.dst_we
    |-> iss0.insn.dst != iss1.insn.dst)
    else $error("pair writes one register");
  pair_dep_a: assert property (iss0.valid && iss1.valid && iss0.insn.dst_we && iss1.insn.src_a_en
    |-> iss1.insn.src_a != iss0.insn.dst)
    else $error("dependent pair issued together");
  hazard_hold_a: assert property (mem_hazard_busy [*3] |-> !short_any)
    else $error("short op issued under memory hazard");
  memory_event_a_evt_a: assert property (ev_memory_event_a == $past(mem_memory_event_a))
    else $error("memory_event_a event mismatch");
  assist_evt_a: assert property (ev_event_b == $past(retire.valid && retire.event_b))
    else $error("assist event mismatch");
  simd_evt_a: assert property (ev_simd_retired_by_type_event == ($past(retire.valid && retire.simd)
    ? 4'h1 << $past(retire.simd_type) : 4'h0))
    else $error("simd retire event mismatch");
  imul_lat_a: assert property (iss0.valid && iss0.insn.op == OP_IMUL32 |-> iss0.lat == 7'h05)
    else $error("multiply latency wrong");
endmodule

bind iilc_issue_ctrl iilc_issue_ctrl_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .fe_valid(fe_valid), .fe_ready(fe_ready),
  .mem_hazard_busy(mem_hazard_busy), .mem_memory_event_a(mem_memory_event_a), .retire(retire),
  .iss0(iss0), .iss1(iss1), .ev_memory_event_a(ev_memory_event_a),
  .ev_simd_retired_by_type_event(ev_simd_retired_by_type_event), .ev_event_b(ev_event_b)
);

`default_nettype wire

// ---- iilc_fe_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module iilc_fe_model
  import iilc_pkg::*;
(
  input  wire logic                  core_clk,
  output logic                       fe_valid,
  output iilc_pkg::iilc_insn_t       fe_insn0,
  output iilc_pkg::iilc_insn_t       fe_insn1,
  input  wire logic                  fe_ready,
  output logic                       timed_out
);
  initial begin
    fe_valid = 1'b0;
    fe_insn0 = '0;
    fe_insn1 = '0;
    timed_out = 1'b0;
  end

  // Holds the pair until a take edge; idle cycles model a slow front end
  task automatic send(input iilc_insn_t i0, input iilc_insn_t i1, input int idle);
    int n;
    repeat (idle) begin
      @(posedge core_clk);
      #1;
    end
    fe_valid = 1'b1;
    fe_insn0 = i0;
    fe_insn1 = i1;
    n = 0;
    while (fe_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    timed_out = (n >= 50);
    fe_valid = 1'b0;
    // Released lines show garbage so stale values are never trusted
    fe_insn0 = ~i0;
    fe_insn1 = ~i1;
  endtask
endmodule

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import iilc_pkg::*;
  logic         core_clk, rst, fe_valid, fe_ready, mem_hazard_busy, mem_memory_event_a, fe_to;
  iilc_insn_t   fe_insn0, fe_insn1;
  iilc_retire_t retire;
  iilc_issue_t  iss0, iss1;
  logic         ev_mem, ev_ds, ev_db, ev_b, rs_prev, fa_prev, sv_prev;
  logic [3:0]   ev_simd;
  logic [1:0]   st_prev;
  logic [31:0]  r;
  int           miscompares = 0, tests_run = 0, cyc = 0, seed = 32'hae91;
  int           busy_n, start_n;
  int           ts[$];
  iilc_op_t     exp_q[$];

  iilc_issue_ctrl u_dut (
    .core_clk(core_clk), .rst(rst), .fe_valid(fe_valid), .fe_insn0(fe_insn0),
    .fe_insn1(fe_insn1), .fe_ready(fe_ready), .mem_hazard_busy(mem_hazard_busy),
    .mem_memory_event_a(mem_memory_event_a), .retire(retire), .iss0(iss0), .iss1(iss1),
    .ev_memory_event_a(ev_mem), .ev_div_start(ev_ds), .ev_div_busy_cycle(ev_db),
    .ev_simd_retired_by_type_event(ev_simd), .ev_event_b(ev_b)
  );

  iilc_fe_model u_fe (
    .core_clk(core_clk), .fe_valid(fe_valid), .fe_insn0(fe_insn0),
    .fe_insn1(fe_insn1), .fe_ready(fe_ready), .timed_out(fe_to)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic int exp_lat(iilc_op_t op);
    case (op)
      OP_ALU, OP_SHIFT_IMM: return 1;
      OP_SHIFT_REG: return 3;
      OP_IMUL32: return 5;
      OP_IMUL16: return 6;
      default: return 0;
    endcase
  endfunction

  task automatic take(input iilc_issue_t s);
    if (exp_q.size() == 0) begin
      chk("spurious issue", 1, 0);
      return;
    end
    chk("issued op", s.insn.op, exp_q[0]);
    if (exp_lat(exp_q[0]) > 0) chk("lat", s.lat, exp_lat(exp_q[0]));
    void'(exp_q.pop_front());
    ts.push_back(cyc);
  endtask

  // Model of events and issue order, sampled once outputs have settled
  always @(posedge core_clk) begin
    cyc++;
    #2;
    if (!rst) begin
      chk("memory_event_a event", ev_mem, rs_prev);
      chk("assist event", ev_b, fa_prev);
      chk("simd event", ev_simd, sv_prev ? 4'h1 << st_prev : 4'h0);
      if (iss0.valid === 1'b1) take(iss0);
      if (iss1.valid === 1'b1) take(iss1);
      busy_n += (ev_db === 1'b1);
      start_n += (ev_ds === 1'b1);
    end
    rs_prev = mem_memory_event_a;
    fa_prev = retire.valid && retire.event_b;
    sv_prev = retire.valid && retire.simd;
    st_prev = retire.simd_type;
  end

  always @(posedge core_clk) begin
    #1;
    if (!rst) begin
      r = $random(seed);
      retire = '{valid: r[0], simd: r[1], simd_type: r[3:2], event_b: r[4]};
      mem_memory_event_a = r[5];
    end
  end

  // One pair per scenario, scoreboard drained in between so gaps stay isolated
  task automatic pair(input iilc_op_t o0, input iilc_op_t o1, input logic dep, input int gap,
                      input logic [6:0] bits = 7'h00, input int hz = 0);
    iilc_insn_t a, b;
    int n;
    a = '0;
    b = '0;
    a.op = o0;
    a.dst = (o1 == OP_SHIFT_REG && !dep) ? COUNT_REG : 4'h3;
    a.dst_we = 1'b1;
    a.narrow = (o0 == OP_LEA);
    a.line_cross = 1'b1;
    a.div_bits = bits;
    b.op = o1;
    b.dst = 4'h4;
    b.dst_we = 1'b1;
    b.src_a = dep ? 4'h3 : 4'h7;
    b.src_a_en = 1'b1;
    b.sub_byte = 2'h1;
    @(posedge core_clk);
    #1;
    mem_hazard_busy = (hz != 0);
    ts.delete();
    exp_q.push_back(o0);
    exp_q.push_back(o1);
    busy_n = 0;
    start_n = 0;
    u_fe.send(a, b, 0);
    chk("front end take", fe_to, 1'b0);
    if (hz != 0) begin
      repeat (hz) @(posedge core_clk);
      chk("held by hazard", ts.size(), 0);
      #1;
      mem_hazard_busy = 1'b0;
    end
    n = 0;
    while (ts.size() < 2 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 60) begin
      chk("issue wait", ts.size(), 2);
      report_and_stop();
    end
    chk("issue gap", ts[1] - ts[0], gap);
    repeat (25) @(posedge core_clk);
  endtask

  initial begin
    rst = 1'b1;
    mem_hazard_busy = 1'b0;
    mem_memory_event_a = 1'b0;
    retire = '0;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    pair(OP_IMUL32, OP_ALU, 0, 4);
    pair(OP_IMUL32, OP_IMUL32, 0, 1);
    pair(OP_IMUL32, OP_ADD_PS, 0, 0);
    pair(OP_IMUL32, OP_ALU, 1, 5);
    pair(OP_IMUL16, OP_IMUL32, 1, 6);
    pair(OP_ALU, OP_SHIFT_REG, 0, 1);
    pair(OP_SHIFT_REG, OP_ALU, 1, 3);
    pair(OP_SHIFT_IMM, OP_ALU, 1, 1);
    pair(OP_ALU, OP_ALU, 0, 0, 7'h00, 6);
    pair(OP_LEA, OP_ALU, 1, 2);
    pair(OP_ADD_PD, OP_ADD_PD, 0, 5);
    pair(OP_ADD_PS, OP_ADD_PS, 1, 5);
    pair(OP_ADD_PS, OP_ALU, 1, 7);
    pair(OP_MUL_SS, OP_MUL_SS, 0, 1);
    pair(OP_MUL_SS, OP_ADD_PS, 1, 4);
    pair(OP_MUL_SD, OP_MUL_PS, 0, 2);
    pair(OP_MUL_PD, OP_MUL_SS, 0, 9);
    pair(OP_UNALIGNED_VECTOR_LOAD, OP_ALU, 1, 3 + 14 + 2);
    pair(OP_DIV, OP_ALU, 1, 2 + 5 + 2, 7'h05);
    chk("divide starts", start_n, 1);
    chk("divider busy cycles", busy_n, 2 + 5);
    report_and_stop();
  end
endmodule

`default_nettype wire
